// ===== logic/msic_top.sv
// Behaviour
// - no link activity in sensor powerdown or reset
// - controller is always master, makes clock
// - select enables link, pins switch function
// - writes: controller drives clock and mosi
// - reads: address, turnaround wait, sensor answers
// - shift mosi out, capture miso, bytewise
// - poll motion deltas at regular interval
// - burst: continuous clocking, single address phase; firmware and frame bursts pause the clock high between bytes
// - firmware download streams image in burst
// - every single-bit quadrature change counts one step; a two-bit jump counts none
// - direction from previous versus current state
// - buttons active low, pulled up
// - buttons debounced for about 16 ms
// - three buttons: left, wheel, right
// - core clock selects 6 or 12 MHz
// - firmware download required after reset
`timescale 1ns/1ps
module msic_top
  import msic_pkg::*;
#(
  parameter int unsigned DEBOUNCE_CYCLES   = DEBOUNCE_CYC,
  parameter int unsigned POLL_CYCLES       = POLL_CYC,
  parameter int unsigned FRAME_BYTES       = FRAME_BYTES_DEF,
  parameter logic [7:0]  MOTION_BURST_ADDR = MOTION_BURST_ADDR_DEF
)(
  // system
  input  wire logic        CLK_SYS,
  input  wire logic        RESET_N,
  // apb slave
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  // sensor link
  output logic             LINK_SELECT_N,
  output logic             CLOCK_PIN,
  output logic             CLOCK_PIN_OE,
  output logic             MOSI_PIN,
  output logic             MOSI_PIN_OE,
  input  wire logic        MISO_PIN,
  output logic             SENSOR_POWERDOWN_N,
  output logic             SENSOR_RESET,
  output logic             CORE_CLK_12M,
  // wheel and buttons
  input  wire logic [1:0]  WHEEL_QUAD,
  input  wire logic [2:0]  BUTTON_N
);
  msic_state_e  state_q;
  msic_motion_s mb_q;
  logic [3:0]  ctrl_q;
  logic [2:0]  gpio_q;
  logic [2:0]  op_q;
  logic        addr_ph_q;
  logic [7:0]  sh_q;
  logic [7:0]  wdata_q;
  logic [2:0]  bit_q;
  logic        sclk_q;
  logic        mosi_q;
  logic        cs_q;
  logic [15:0] tmr_q;
  logic [15:0] cnt_q;
  logic [7:0]  rdata_q;
  logic [7:0]  fw_byte_q;
  logic        fw_full_q;
  logic [7:0]  frm_byte_q;
  logic        frm_full_q;
  logic        fw_loaded_q;
  logic [31:0] poll_q;
  logic        poll_pend_q;
  logic signed [15:0] acc_x_q;
  logic signed [15:0] acc_y_q;
  logic signed [7:0]  acc_w_q;
  logic        miso_s1_q;
  logic        miso_s2_q;
  logic [31:0] prdata_q;
  logic        pready_q;
  logic        pslverr_q;
  logic        sel_n_q;
  logic        clk_pin_q;
  logic        clk_oe_q;
  logic        mosi_pin_q;
  logic        mosi_oe_q;
  logic [31:0] rd_mux;
  logic [2:0]  btn_pressed;
  logic        wheel_inc;
  logic        wheel_dec;

  function automatic logic [15:0] sext8(input logic [7:0] b);
    sext8 = {{8{b[7]}}, b};
  endfunction

  // bus decode
  wire acc_ph   = PSEL && PENABLE;
  wire is_fwd   = (PADDR == OFS_FW_DATA);
  wire is_frm   = (PADDR == OFS_FRAME_DATA);
  wire frm_run  = (state_q != ST_IDLE) && (op_q == OP_FRAME);
  // back-pressure: firmware slot full, or frame byte not yet there
  wire can_go   = !(is_fwd && PWRITE && fw_full_q) &&
                  !(is_frm && !PWRITE && frm_run && !frm_full_q);
  wire take     = acc_ph && !pready_q && can_go;
  wire wr_take  = take && PWRITE;
  wire rd_take  = take && !PWRITE;
  wire mapped   = (PADDR[1:0] == 2'h0) && (PADDR <= OFS_GPIO);
  wire wr_ctrl  = wr_take && (PADDR == OFS_CTRL);
  wire wr_cmd   = wr_take && (PADDR == OFS_CMD);
  wire wr_gpio  = wr_take && (PADDR == OFS_GPIO);
  wire wr_fw    = wr_take && is_fwd;
  wire rd_frm   = rd_take && is_frm;
  wire rd_x     = rd_take && (PADDR == OFS_MOTION_X);
  wire rd_y     = rd_take && (PADDR == OFS_MOTION_Y);
  wire rd_w     = rd_take && (PADDR == OFS_WHEEL);

  // engine decode
  wire link_ok  = ctrl_q[CTRL_PD_N_BIT] && !ctrl_q[CTRL_SRST_BIT];
  wire idle     = (state_q == ST_IDLE);
  wire [2:0] cmd_op = PWDATA[CMD_OP_LSB +: 3];
  wire cmd_go   = wr_cmd && idle && link_ok && (cmd_op <= OP_FRAME);
  // polling waits for the sensor program to be loaded
  wire poll_go  = poll_pend_q && ctrl_q[CTRL_POLL_BIT] && fw_loaded_q &&
                  idle && link_ok && !cmd_go;
  wire poll_hit = (poll_q == POLL_CYCLES - 1);
  wire tick     = (tmr_q == 16'h0000);
  wire rise     = (state_q == ST_SHIFT) && tick && !sclk_q;
  wire byte_end = rise && (bit_q == 3'h7);
  wire [7:0] rx = {sh_q[6:0], miso_s2_q};
  wire is_tx    = addr_ph_q || (op_q == OP_WRITE) || (op_q == OP_FW);
  wire mb_add_x = byte_end && !addr_ph_q && (op_q == OP_MOTION) && (cnt_q == 16'h0001);
  wire mb_add_y = byte_end && !addr_ph_q && (op_q == OP_MOTION) && (cnt_q == 16'h0002);
  wire last_mb  = (cnt_q == 16'(BURST_BYTES - 1));
  wire last_fw  = (cnt_q == 16'(FW_BYTES - 1));
  wire last_frm = (cnt_q == 16'(FRAME_BYTES - 1));
  // closing byte of any operation arms the select hold
  wire last_any = (op_q == OP_WRITE) || (op_q == OP_READ) ||
                  (op_q == OP_MOTION && last_mb) || (op_q == OP_FW && last_fw) ||
                  (op_q == OP_FRAME && last_frm);

  // accumulators: a read clears, a coinciding delta survives
  wire signed [15:0] acc_x_d = (rd_x ? 16'sh0000 : acc_x_q) +
                               (mb_add_x ? $signed(sext8(rx)) : 16'sh0000);
  wire signed [15:0] acc_y_d = (rd_y ? 16'sh0000 : acc_y_q) +
                               (mb_add_y ? $signed(sext8(rx)) : 16'sh0000);
  wire signed [7:0]  acc_w_b = rd_w ? 8'sh00 : acc_w_q;
  wire signed [7:0]  acc_w_d = acc_w_b + (wheel_inc ? 8'sh01 : 8'sh00) -
                               (wheel_dec ? 8'sh01 : 8'sh00);

  always_comb begin
    rd_mux = 32'h0000_0000;
    case (PADDR)
      OFS_CTRL:       rd_mux = {28'h0000000, ctrl_q};
      OFS_STATUS:     rd_mux = {26'h0000000, miso_s2_q, link_ok, fw_full_q,
                                frm_full_q, fw_loaded_q, !idle};
      OFS_RDATA:      rd_mux = {24'h000000, rdata_q};
      OFS_MOTION_X:   rd_mux = {{16{acc_x_q[15]}}, acc_x_q};
      OFS_MOTION_Y:   rd_mux = {{16{acc_y_q[15]}}, acc_y_q};
      OFS_WHEEL:      rd_mux = {{24{acc_w_q[7]}}, acc_w_q};
      OFS_BUTTONS:    rd_mux = {29'h00000000, btn_pressed};
      OFS_BURST_INFO: rd_mux = {mb_q.shut_hi, mb_q.shut_lo, mb_q.surface_quality,
                                mb_q.status};
      OFS_MAX_PIXEL:  rd_mux = {24'h000000, mb_q.maxpix};
      OFS_FRAME_DATA: rd_mux = {24'h000000, frm_byte_q};
      OFS_GPIO:       rd_mux = {29'h00000000, gpio_q};
      default:        rd_mux = 32'h0000_0000;
    endcase
  end

  // apb slave, answer one cycle into the access phase unless stalled
  always_ff @(posedge CLK_SYS) begin
    if (!RESET_N) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
      ctrl_q    <= CTRL_RST;
      gpio_q    <= GPIO_RST;
    end else begin
      pready_q  <= take;
      pslverr_q <= take && !mapped;
      if (rd_take) begin
        prdata_q <= rd_mux;
      end
      if (wr_ctrl) begin
        ctrl_q <= PWDATA[3:0];
      end
      if (wr_gpio) begin
        gpio_q <= PWDATA[2:0];
      end
    end
  end

  // motion poll timer
  always_ff @(posedge CLK_SYS) begin
    if (!RESET_N) begin
      poll_q      <= 32'h0000_0000;
      poll_pend_q <= 1'b0;
      acc_x_q     <= 16'sh0000;
      acc_y_q     <= 16'sh0000;
      acc_w_q     <= 8'sh00;
    end else begin
      poll_q      <= poll_hit ? 32'h0000_0000 : poll_q + 32'h0000_0001;
      poll_pend_q <= poll_hit || (poll_pend_q && !poll_go);
      acc_x_q     <= acc_x_d;
      acc_y_q     <= acc_y_d;
      acc_w_q     <= acc_w_d;
    end
  end

  // serial engine, clock idles high, data out on fall, sampled on rise
  always_ff @(posedge CLK_SYS) begin
    if (!RESET_N) begin
      state_q     <= ST_IDLE;
      op_q        <= OP_WRITE;
      addr_ph_q   <= 1'b0;
      sh_q        <= 8'h00;
      wdata_q     <= 8'h00;
      bit_q       <= 3'h0;
      sclk_q      <= 1'b1;
      mosi_q      <= 1'b0;
      cs_q        <= 1'b0;
      tmr_q       <= 16'h0000;
      cnt_q       <= 16'h0000;
      rdata_q     <= 8'h00;
      mb_q        <= '0;
      fw_byte_q   <= 8'h00;
      fw_full_q   <= 1'b0;
      frm_byte_q  <= 8'h00;
      frm_full_q  <= 1'b0;
      fw_loaded_q <= 1'b0;
    end else begin
      if (rd_frm) begin
        frm_full_q <= 1'b0;
      end
      if (wr_fw) begin
        fw_byte_q <= PWDATA[7:0];
        fw_full_q <= 1'b1;
      end else if (idle) begin
        fw_full_q <= 1'b0;
      end
      if (!link_ok) begin
        state_q <= ST_IDLE;
        cs_q    <= 1'b0;
        sclk_q  <= 1'b1;
      end else begin
        case (state_q)
          ST_IDLE: begin
            if (cmd_go || poll_go) begin
              op_q      <= cmd_go ? cmd_op : OP_MOTION;
              sh_q      <= cmd_go ? PWDATA[CMD_ADDR_LSB +: 8] : MOTION_BURST_ADDR;
              wdata_q   <= PWDATA[CMD_DATA_LSB +: 8];
              addr_ph_q <= 1'b1;
              bit_q     <= 3'h0;
              cnt_q     <= 16'h0000;
              cs_q      <= 1'b1;
              tmr_q     <= 16'(SCLK_HALF_CYC - 1);
              state_q   <= ST_SHIFT;
              if (cmd_go && (cmd_op == OP_FW)) begin
                fw_loaded_q <= 1'b0;
              end
            end
          end
          ST_SHIFT: begin
            if (!tick) begin
              tmr_q <= tmr_q - 16'h0001;
            end else if (sclk_q) begin
              tmr_q  <= 16'(SCLK_HALF_CYC - 1);
              sclk_q <= 1'b0;
              mosi_q <= is_tx ? sh_q[7] : 1'b0;
            end else begin
              tmr_q  <= 16'(SCLK_HALF_CYC - 1);
              sclk_q <= 1'b1;
              sh_q   <= rx;
              bit_q  <= bit_q + 3'h1;
              if (byte_end && addr_ph_q) begin
                addr_ph_q <= 1'b0;
                if (op_q == OP_WRITE) begin
                  sh_q <= wdata_q;
                end else if (op_q == OP_FW) begin
                  state_q <= ST_WAIT;
                end else begin
                  tmr_q   <= 16'(READ_ADDRESS_TURNAROUND_DELAY_CYC - 1);
                  state_q <= ST_TURN;
                end
              end else if (byte_end) begin
                cnt_q <= cnt_q + 16'h0001;
                case (op_q)
                  OP_READ: begin
                    rdata_q <= rx;
                    state_q <= ST_HOLD;
                  end
                  OP_MOTION: begin
                    // sensor order: status, dx, dy, quality, shutter, max pixel
                    mb_q    <= {mb_q[47:0], rx};
                    state_q <= last_mb ? ST_HOLD : ST_SHIFT;
                  end
                  OP_FW: begin
                    fw_loaded_q <= last_fw;
                    state_q     <= last_fw ? ST_HOLD : ST_WAIT;
                  end
                  OP_FRAME: begin
                    frm_byte_q <= rx;
                    frm_full_q <= 1'b1;
                    state_q    <= last_frm ? ST_HOLD : ST_WAIT;
                  end
                  default: state_q <= ST_HOLD;
                endcase
                if (last_any) begin
                  tmr_q <= 16'(CS_HOLD_CYC - 1);
                end
              end
            end
          end
          ST_TURN: begin
            // mosi left alone: it must not move while the clock is high
            if (!tick) begin
              tmr_q <= tmr_q - 16'h0001;
            end else begin
              tmr_q   <= 16'(SCLK_HALF_CYC - 1);
              state_q <= ST_SHIFT;
            end
          end
          ST_WAIT: begin
            // clock pauses high while software feeds or drains a byte
            if (op_q == OP_FW && fw_full_q && !wr_fw) begin
              sh_q      <= fw_byte_q;
              fw_full_q <= 1'b0;
              tmr_q     <= 16'(SCLK_HALF_CYC - 1);
              state_q   <= ST_SHIFT;
            end else if (op_q == OP_FRAME && !frm_full_q) begin
              tmr_q   <= 16'(SCLK_HALF_CYC - 1);
              state_q <= ST_SHIFT;
            end else if (op_q != OP_FW && op_q != OP_FRAME) begin
              state_q <= ST_HOLD;
            end
          end
          ST_HOLD: begin
            if (!tick) begin
              tmr_q <= tmr_q - 16'h0001;
            end else begin
              cs_q    <= 1'b0;
              state_q <= ST_IDLE;
            end
          end
          default: state_q <= ST_IDLE;
        endcase
      end
    end
  end

  // pins: registered, serial function only while select is active
  always_ff @(posedge CLK_SYS) begin
    if (!RESET_N) begin
      miso_s1_q  <= 1'b0;
      miso_s2_q  <= 1'b0;
      sel_n_q    <= 1'b1;
      clk_pin_q  <= 1'b0;
      clk_oe_q   <= 1'b0;
      mosi_pin_q <= 1'b0;
      mosi_oe_q  <= 1'b0;
    end else begin
      miso_s1_q  <= MISO_PIN;
      miso_s2_q  <= miso_s1_q;
      sel_n_q    <= !cs_q;
      clk_pin_q  <= cs_q ? sclk_q : gpio_q[GPIO_CLK_BIT];
      clk_oe_q   <= cs_q || gpio_q[GPIO_OE_BIT];
      mosi_pin_q <= cs_q ? mosi_q : gpio_q[GPIO_MOSI_BIT];
      mosi_oe_q  <= cs_q || gpio_q[GPIO_OE_BIT];
    end
  end

  msic_quad u_quad (
    .clk   (CLK_SYS),
    .rst_n (RESET_N),
    .quad  (WHEEL_QUAD),
    .inc   (wheel_inc),
    .dec   (wheel_dec)
  );

  // left, wheel, right
  msic_debounce #(
    .WIDTH  (3),
    .CYCLES (DEBOUNCE_CYCLES)
  ) u_btn (
    .clk     (CLK_SYS),
    .rst_n   (RESET_N),
    .raw_n   (BUTTON_N),
    .pressed (btn_pressed)
  );

  assign PRDATA             = prdata_q;
  assign PREADY             = pready_q;
  assign PSLVERR            = pslverr_q;
  assign LINK_SELECT_N      = sel_n_q;
  assign CLOCK_PIN          = clk_pin_q;
  assign CLOCK_PIN_OE       = clk_oe_q;
  assign MOSI_PIN           = mosi_pin_q;
  assign MOSI_PIN_OE        = mosi_oe_q;
  assign SENSOR_POWERDOWN_N = ctrl_q[CTRL_PD_N_BIT];
  assign SENSOR_RESET       = ctrl_q[CTRL_SRST_BIT];
  assign CORE_CLK_12M       = ctrl_q[CTRL_CLK12_BIT];
endmodule

// ===== logic/msic_pkg.sv
package msic_pkg;
  // timing
  localparam int unsigned SYS_CLK_MHZ        = 200;
  localparam int unsigned SCLK_HALF_NS       = 250;
  localparam int unsigned SCLK_HALF_CYC      = (SCLK_HALF_NS * SYS_CLK_MHZ + 999) / 1000;
  localparam int unsigned READ_ADDRESS_TURNAROUND_DELAY_NS  = 4000;
  localparam int unsigned READ_ADDRESS_TURNAROUND_DELAY_CYC =
    (READ_ADDRESS_TURNAROUND_DELAY_NS * SYS_CLK_MHZ + 999) / 1000;
  localparam int unsigned CS_HOLD_NS         = 1000;
  localparam int unsigned CS_HOLD_CYC        = (CS_HOLD_NS * SYS_CLK_MHZ + 999) / 1000;
  localparam int unsigned DEBOUNCE_MS        = 16;
  localparam int unsigned DEBOUNCE_CYC       = DEBOUNCE_MS * SYS_CLK_MHZ * 1000;
  localparam int unsigned POLL_US            = 1000;
  localparam int unsigned POLL_CYC           = POLL_US * SYS_CLK_MHZ;
  // transfer sizes
  localparam int unsigned FW_BYTES           = 1986;
  localparam int unsigned BURST_BYTES        = 7;
  localparam int unsigned FRAME_BYTES_DEF    = 900;
  localparam logic [7:0]  MOTION_BURST_ADDR_DEF = 8'h00;
  // register offsets
  localparam logic [7:0]  OFS_CTRL           = 8'h00;
  localparam logic [7:0]  OFS_CMD            = 8'h04;
  localparam logic [7:0]  OFS_STATUS         = 8'h08;
  localparam logic [7:0]  OFS_RDATA          = 8'h0C;
  localparam logic [7:0]  OFS_MOTION_X       = 8'h10;
  localparam logic [7:0]  OFS_MOTION_Y       = 8'h14;
  localparam logic [7:0]  OFS_WHEEL          = 8'h18;
  localparam logic [7:0]  OFS_BUTTONS        = 8'h1C;
  localparam logic [7:0]  OFS_BURST_INFO     = 8'h20;
  localparam logic [7:0]  OFS_MAX_PIXEL      = 8'h24;
  localparam logic [7:0]  OFS_FW_DATA        = 8'h28;
  localparam logic [7:0]  OFS_FRAME_DATA     = 8'h2C;
  localparam logic [7:0]  OFS_GPIO           = 8'h30;
  // fields
  localparam int unsigned CTRL_PD_N_BIT      = 0;
  localparam int unsigned CTRL_SRST_BIT      = 1;
  localparam int unsigned CTRL_POLL_BIT      = 2;
  localparam int unsigned CTRL_CLK12_BIT     = 3;
  localparam int unsigned CMD_ADDR_LSB       = 0;
  localparam int unsigned CMD_DATA_LSB       = 8;
  localparam int unsigned CMD_OP_LSB         = 16;
  localparam int unsigned GPIO_CLK_BIT       = 0;
  localparam int unsigned GPIO_MOSI_BIT      = 1;
  localparam int unsigned GPIO_OE_BIT        = 2;
  // reset values
  localparam logic [3:0]  CTRL_RST           = 4'h1;
  localparam logic [2:0]  GPIO_RST           = 3'h0;
  // operations
  localparam logic [2:0]  OP_WRITE           = 3'h0;
  localparam logic [2:0]  OP_READ            = 3'h1;
  localparam logic [2:0]  OP_MOTION          = 3'h2;
  localparam logic [2:0]  OP_FW              = 3'h3;
  localparam logic [2:0]  OP_FRAME           = 3'h4;

  typedef enum logic [2:0] {ST_IDLE, ST_SHIFT, ST_TURN, ST_WAIT, ST_HOLD} msic_state_e;

  typedef struct packed {
    logic [7:0] status;
    logic [7:0] dx;
    logic [7:0] dy;
    logic [7:0] surface_quality;
    logic [7:0] shut_hi;
    logic [7:0] shut_lo;
    logic [7:0] maxpix;
  } msic_motion_s;
endpackage

// ===== logic/msic_quad.sv
`timescale 1ns/1ps
module msic_quad (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // quadrature pins and step pulses
  input  wire logic [1:0] quad,
  output logic            inc,
  output logic            dec
);
  logic [1:0] s1_q;
  logic [1:0] s2_q;
  logic [1:0] prev_q;
  logic       inc_q;
  logic       dec_q;

  // forward gray walk 00-01-11-10-00
  function automatic logic fwd(input logic [1:0] p, input logic [1:0] c);
    fwd = ({p, c} == 4'h1) || ({p, c} == 4'h7) || ({p, c} == 4'hE) || ({p, c} == 4'h8);
  endfunction

  wire       moved  = (prev_q != s2_q);
  wire       jump   = ((prev_q ^ s2_q) == 2'h3);
  wire       dir_up = fwd(prev_q, s2_q);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s1_q   <= 2'h0;
      s2_q   <= 2'h0;
      prev_q <= 2'h0;
      inc_q  <= 1'b0;
      dec_q  <= 1'b0;
    end else begin
      s1_q   <= quad;
      s2_q   <= s1_q;
      prev_q <= s2_q;
      inc_q  <= moved && !jump && dir_up;
      dec_q  <= moved && !jump && !dir_up;
    end
  end

  assign inc = inc_q;
  assign dec = dec_q;
endmodule

// ===== logic/msic_debounce.sv
`timescale 1ns/1ps
module msic_debounce #(
  parameter int unsigned WIDTH  = 3,
  parameter int unsigned CYCLES = 16
)(
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // raw active-low switches and filtered pressed levels
  input  wire logic [WIDTH-1:0] raw_n,
  output logic      [WIDTH-1:0] pressed
);
  localparam int unsigned CW = $clog2(CYCLES + 1);

  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : gen_btn
      logic          s1_q;
      logic          s2_q;
      logic          stable_q;
      logic [CW-1:0] cnt_q;
      wire           differ = (s2_q != stable_q);
      wire           ripe   = (cnt_q == CW'(CYCLES - 1));
      always_ff @(posedge clk) begin
        if (!rst_n) begin
          s1_q     <= 1'b1;
          s2_q     <= 1'b1;
          stable_q <= 1'b1;
          cnt_q    <= '0;
        end else begin
          s1_q <= raw_n[g];
          s2_q <= s1_q;
          if (!differ) begin
            cnt_q <= '0;
          end else if (ripe) begin
            stable_q <= s2_q;
            cnt_q    <= '0;
          end else begin
            cnt_q <= cnt_q + CW'(1);
          end
        end
      end
      // low level means pressed
      assign pressed[g] = !stable_q;
    end
  endgenerate
endmodule

// ===== testbench/msic_top_asserts.sv
`timescale 1ns/1ps
module msic_top_asserts (
  // system
  input wire logic CLK_SYS,
  input wire logic RESET_N,
  // apb
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PREADY,
  input wire logic PSLVERR,
  // link
  input wire logic LINK_SELECT_N,
  input wire logic CLOCK_PIN,
  input wire logic CLOCK_PIN_OE,
  input wire logic MOSI_PIN,
  input wire logic MOSI_PIN_OE,
  input wire logic SENSOR_POWERDOWN_N,
  input wire logic SENSOR_RESET
);
  // length of the current low clock phase
  logic [15:0] lo_q;
  always_ff @(posedge CLK_SYS) lo_q <= CLOCK_PIN ? 16'h0000 : lo_q + 16'h0001;
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!RESET_N);
  no_start_a: assert property ((!SENSOR_POWERDOWN_N || SENSOR_RESET) && LINK_SELECT_N |=>
    LINK_SELECT_N) else $error("link started while sensor held");
  pins_owned_a: assert property (!LINK_SELECT_N |-> CLOCK_PIN_OE && MOSI_PIN_OE)
    else $error("pins not driven in transfer");
  clk_half_a: assert property ($rose(CLOCK_PIN) && !LINK_SELECT_N && $past(!LINK_SELECT_N)
    |-> lo_q == 16'h0032) else $error("clock low phase wrong");
  lead_in_a: assert property ($fell(LINK_SELECT_N) |-> CLOCK_PIN [*8])
    else $error("clock not idle high at select");
  end_high_a: assert property ($rose(LINK_SELECT_N) |-> $past(CLOCK_PIN))
    else $error("select released mid clock");
  mosi_hold_a: assert property (!LINK_SELECT_N && $past(!LINK_SELECT_N) && CLOCK_PIN
    && $past(CLOCK_PIN) |-> $stable(MOSI_PIN)) else $error("data moved while clock high");
  ready_cause_a: assert property (PREADY |-> $past(PSEL && PENABLE) ##1 !PREADY)
    else $error("ready without access");
  err_ready_a: assert property (PSLVERR |-> PREADY) else $error("error without ready");
  cover property ($fell(LINK_SELECT_N));
  cover property (PSLVERR);
  cover property ($rose(CLOCK_PIN) && !LINK_SELECT_N);
endmodule

bind msic_top msic_top_asserts u_msic_top_asserts (.CLK_SYS(CLK_SYS), .RESET_N(RESET_N),
  .PSEL(PSEL), .PENABLE(PENABLE), .PREADY(PREADY), .PSLVERR(PSLVERR),
  .LINK_SELECT_N(LINK_SELECT_N), .CLOCK_PIN(CLOCK_PIN), .CLOCK_PIN_OE(CLOCK_PIN_OE),
  .MOSI_PIN(MOSI_PIN), .MOSI_PIN_OE(MOSI_PIN_OE), .SENSOR_POWERDOWN_N(SENSOR_POWERDOWN_N),
  .SENSOR_RESET(SENSOR_RESET));

// ===== testbench/msic_sensor_model.sv
`timescale 1ns/1ps
module msic_sensor_model
  import msic_pkg::*;
(
  // link
  input  wire logic select_n,
  input  wire logic sclk,
  input  wire logic mosi,
  output logic      miso
);
  msic_motion_s reply;
  logic [7:0]   addr_q;
  logic [7:0]   wr_q;
  int           nbit;
  initial begin
    miso   = 1'b0;
    nbit   = 0;
    addr_q = 8'h00;
    wr_q   = 8'h00;
    reply  = {8'h80, 8'h05, 8'hFB, 8'h40, 8'h12, 8'h34, 8'h9A};
  end
  always @(negedge select_n) nbit = 0;
  always @(posedge sclk) if (!select_n) begin
    if (nbit < 8) addr_q = {addr_q[6:0], mosi};
    else if (nbit < 16) wr_q = {wr_q[6:0], mosi};
    nbit++;
  end
  // reply only after the address byte; one continuous stream
  always @(negedge sclk) if (!select_n && nbit >= 8 && nbit < 64)
    miso = reply[63 - nbit];
  // released line shows no stale bit
  always @(posedge select_n) miso = ~miso;
endmodule

// ===== testbench/msic_tb_top.sv
`timescale 1ns/1ps
module msic_tb_top
  import msic_pkg::*;
;
  typedef struct packed {logic [7:0] a; logic w; logic [31:0] d;
                         logic [31:0] x; logic e;} msic_row_s;
  logic        CLK_SYS, RESET_N, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, er;
  logic [7:0]  PADDR;
  logic [31:0] PWDATA, PRDATA, rd;
  logic        sel_n, sclk, sclk_oe, mosi, mosi_oe, miso, pd_n, srst, clk12;
  logic [31:0] frm [4] = '{32'h80, 32'h05, 32'hFB, 32'h40};
  logic [1:0]  WHEEL_QUAD;
  logic [2:0]  BUTTON_N;
  int          fails, n_tests;
  logic [1:0]  qseq [7] = '{2'h1, 2'h3, 2'h2, 2'h0, 2'h3, 2'h0, 2'h2};
  msic_row_s   rows [9] = '{'{OFS_CTRL, 1'b0, 32'h0, 32'h1, 1'b0},
    '{OFS_GPIO, 1'b1, 32'h5, 32'h0, 1'b0}, '{OFS_GPIO, 1'b0, 32'h0, 32'h5, 1'b0},
    '{OFS_GPIO, 1'b1, 32'h1, 32'h0, 1'b0}, '{OFS_MOTION_X, 1'b1, 32'hFF, 32'h0, 1'b0},
    '{OFS_MOTION_X, 1'b0, 32'h0, 32'h0, 1'b0}, '{OFS_BUTTONS, 1'b0, 32'h0, 32'h0, 1'b0},
    '{8'h34, 1'b0, 32'h0, 32'h0, 1'b1}, '{8'h02, 1'b0, 32'h0, 32'h0, 1'b1}};
  msic_top #(.DEBOUNCE_CYCLES(20), .POLL_CYCLES(3000), .FRAME_BYTES(4)) u_msic_top (
    .CLK_SYS(CLK_SYS), .RESET_N(RESET_N), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .LINK_SELECT_N(sel_n), .CLOCK_PIN(sclk), .CLOCK_PIN_OE(sclk_oe), .MOSI_PIN(mosi),
    .MOSI_PIN_OE(mosi_oe), .MISO_PIN(miso), .SENSOR_POWERDOWN_N(pd_n), .SENSOR_RESET(srst),
    .CORE_CLK_12M(clk12), .WHEEL_QUAD(WHEEL_QUAD), .BUTTON_N(BUTTON_N));
  msic_sensor_model u_msic_sensor_model (.select_n(sel_n), .sclk(sclk), .mosi(mosi),
    .miso(miso));
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("unexpected %s: expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    PSEL   <= 1'b1;
    PADDR  <= a;
    PWRITE <= w;
    PWDATA <= d;
    @(posedge CLK_SYS);
    PENABLE <= 1'b1;
    do begin
      @(posedge CLK_SYS);
      n++;
    end while (PREADY !== 1'b1 && n < 9999);
    if (PREADY !== 1'b1) fails++;
    rd = PRDATA;
    er = PSLVERR;
    PSEL    <= 1'b0;
    PENABLE <= 1'b0;
    @(posedge CLK_SYS);
  endtask
  task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
    apb(a, 1'b0, 32'h0);
    chk(nm, exp, rd);
  endtask
  // busy can last a whole burst, so poll instead of waiting blind
  task automatic idle();
    int n;
    n = 0;
    do begin
      apb(OFS_STATUS, 1'b0, 32'h0);
      n++;
    end while (rd[0] !== 1'b0 && n < 5000);
    if (rd[0] !== 1'b0) fails++;
  endtask
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    CLK_SYS = 1'b0;
    forever #2.5 CLK_SYS = ~CLK_SYS;
  end
  initial begin
    #400000;
    fails++;
    close_out();
  end
  initial begin
    {RESET_N, PSEL, PENABLE, PWRITE, PADDR, PWDATA, WHEEL_QUAD} = '0;
    BUTTON_N = 3'h7;
    repeat (5) @(posedge CLK_SYS);
    RESET_N <= 1'b1;
    foreach (rows[i]) begin
      apb(rows[i].a, rows[i].w, rows[i].d);
      chk("slave error", {31'h0, rows[i].e}, {31'h0, er});
      if (!rows[i].w && !rows[i].e) chk("read data", rows[i].x, rd);
    end
    apb(OFS_CTRL, 1'b1, 32'h0);
    apb(OFS_CMD, 1'b1, {13'h0, OP_READ, 16'h0042});
    repeat (100) @(posedge CLK_SYS);
    chk("select in powerdown", 32'h1, {31'h0, sel_n});
    apb(OFS_CTRL, 1'b1, 32'h9);
    chk("core clock select", 32'h1, {31'h0, clk12});
    apb(OFS_CMD, 1'b1, {13'h0, OP_READ, 16'h0042});
    idle();
    rdchk("single read", OFS_RDATA, 32'h80);
    chk("sent address", 32'h42, {24'h0, u_msic_sensor_model.addr_q});
    apb(OFS_CMD, 1'b1, {13'h0, OP_MOTION, 8'h00, MOTION_BURST_ADDR_DEF});
    idle();
    rdchk("burst info", OFS_BURST_INFO, 32'h12344080);
    rdchk("max pixel", OFS_MAX_PIXEL, 32'h9A);
    rdchk("motion x", OFS_MOTION_X, 32'h5);
    rdchk("motion y", OFS_MOTION_Y, 32'hFFFFFFFB);
    rdchk("motion x cleared", OFS_MOTION_X, 32'h0);
    apb(OFS_CMD, 1'b1, {13'h0, OP_WRITE, 16'h5C8A});
    idle();
    chk("sent data", 32'h5C, {24'h0, u_msic_sensor_model.wr_q});
    apb(OFS_CMD, 1'b1, {13'h0, OP_FRAME, 16'h0012});
    foreach (frm[i]) rdchk("frame byte", OFS_FRAME_DATA, frm[i]);
    idle();
    apb(OFS_CMD, 1'b1, {13'h0, OP_FW, 16'h0062});
    apb(OFS_FW_DATA, 1'b1, 32'hA7);
    repeat (2000) @(posedge CLK_SYS);
    chk("firmware byte", 32'hA7, {24'h0, u_msic_sensor_model.wr_q});
    apb(OFS_CTRL, 1'b1, 32'h3);
    repeat (4) @(posedge CLK_SYS);
    chk("select after abort", 32'h1, {31'h0, sel_n});
    apb(OFS_CTRL, 1'b1, 32'h1);
    foreach (qseq[i]) begin
      WHEEL_QUAD <= qseq[i];
      repeat (8) @(posedge CLK_SYS);
    end
    rdchk("wheel", OFS_WHEEL, 32'h3);
    BUTTON_N <= 3'h3;
    repeat (5) @(posedge CLK_SYS);
    BUTTON_N <= 3'h5;
    repeat (60) @(posedge CLK_SYS);
    rdchk("buttons", OFS_BUTTONS, 32'h2);
    close_out();
  end
endmodule
